// *** rtl/fct_pkg.sv ***
// Shared constants for the FDL codeword message transceiver.
// Assumes an 8-bit processor port with one-cycle read and write strobes.
package fct_pkg;

   // -------------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFSET = 8'hA0;
   localparam logic [7:0] TX_CW_OFFSET = 8'hA1;
   localparam logic [7:0] RX_CW_OFFSET = 8'hA2;
   localparam logic [7:0] STATUS_OFFSET = 8'hA3;

   // -------------------------------------------------------------------
   // Control register fields
   // -------------------------------------------------------------------
   localparam int CTRL_RX_SEARCH_BIT = 7;
   localparam int CTRL_RX_INTEG_BIT = 6;
   localparam int CTRL_RX_LEN_LSB = 4;
   localparam int CTRL_TX_LEN_LSB = 2;
   localparam int CTRL_TX_MODE_LSB = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Receive codeword register flags
   localparam int RX_LOST_BIT = 7;
   localparam int RX_FRESH_BIT = 6;
   localparam logic [5:0] CW_RESET = 6'h00;

   // Status register flags
   localparam int STAT_TX_ACTIVE_BIT = 7;
   localparam int STAT_RX_ACTIVE_BIT = 6;

   // -------------------------------------------------------------------
   // Encodings and counts
   // -------------------------------------------------------------------
   localparam logic [1:0] LEN_ONE = 2'h0;
   localparam logic [1:0] LEN_TEN = 2'h1;
   localparam logic [1:0] LEN_25 = 2'h2;
   localparam logic [1:0] LEN_CONT = 2'h3;
   localparam logic [1:0] MODE_CW_PRIO = 2'h2;
   localparam logic [1:0] MODE_DL_PRIO = 2'h3;
   localparam logic [4:0] COUNT_ONE = 5'h01;
   localparam logic [4:0] COUNT_TEN = 5'h0A;
   localparam logic [4:0] COUNT_25 = 5'h19;
   localparam logic [4:0] COUNT_MAX = 5'h1F;
   localparam logic [7:0] FLAG_ONES = 8'hFF;
   localparam logic [3:0] PATTERN_LAST_BIT = 4'hF;
   // One pattern lasts 16 FDL bits, 4 ms at the 4 kbit/s FDL rate
   localparam int PATTERN_MS = 4;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_WAIT = 3'b010,
      TX_SEND = 3'b100
   } fct_tx_state_t;

   // Pattern count for a length code; the continuous code also returns one
   function automatic logic [4:0] fct_len_count(input logic [1:0] sel);
      case (sel)
         LEN_TEN: fct_len_count = COUNT_TEN;
         LEN_25: fct_len_count = COUNT_25;
         default: fct_len_count = COUNT_ONE;
      endcase
   endfunction

endpackage

// *** rtl/fct_rx_pattern_finder.sv ***
// Serial search for one 16-bit codeword pattern in the received FDL bits.
// Assumes bit_en_i pulses once per FDL bit, bits arriving first bit first.
`timescale 1ns/1ns
module fct_rx_pattern_finder
   import fct_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic enable_i,
   input wire logic bit_en_i,
   input wire logic bit_i,
   output logic found_o,
   output logic [5:0] codeword_o
);

   logic [15:0] shift_q;
   logic [15:0] shift_d;
   logic match;

   assign shift_d = {bit_i, shift_q[15:1]};
   // Eight ones first, then a zero, six codeword bits and a closing zero
   assign match = (shift_d[7:0] == FLAG_ONES) && !shift_d[8] && !shift_d[15];

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         shift_q <= 16'h0000;
         found_o <= 1'b0;
         codeword_o <= CW_RESET;
      end else if (!enable_i) begin
         shift_q <= 16'h0000;
         found_o <= 1'b0;
      end else if (bit_en_i) begin
         // Flushing after a hit keeps one pattern from being seen twice
         shift_q <= match ? 16'h0000 : shift_d;
         found_o <= match;
         if (match) begin
            codeword_o <= shift_d[14:9];
         end
      end else begin
         found_o <= 1'b0;
      end
   end

endmodule

// *** rtl/fct_tx_pattern_shifter.sv ***
// Shifts one 16-bit codeword pattern out, first bit first.
// Assumes the caller loads a codeword and strobes shift_i once per FDL bit.
`timescale 1ns/1ns
module fct_tx_pattern_shifter
   import fct_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic load_i,
   input wire logic [5:0] codeword_i,
   input wire logic shift_i,
   output logic bit_o,
   output logic last_o
);

   logic [15:0] pattern_q;
   logic [3:0] index_q;

   assign bit_o = pattern_q[0];
   assign last_o = shift_i && (index_q == PATTERN_LAST_BIT);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         pattern_q <= {1'b0, CW_RESET, 1'b0, FLAG_ONES};
         index_q <= 4'h0;
      end else if (load_i) begin
         pattern_q <= {1'b0, codeword_i, 1'b0, FLAG_ONES};
         index_q <= 4'h0;
      end else if (shift_i) begin
         pattern_q <= {1'b0, pattern_q[15:1]};
         index_q <= index_q + 4'h1;
      end
   end

endmodule

// *** rtl/fct_transceiver.sv ***
// FDL codeword message transceiver: register port, receive qualification
// and transmit sequencing with priority against the first data link.
// Assumes the framer supplies one-cycle bit strobes for the FDL slot bits
// chosen for the first data-link controller, and runs on the line clock.
//
// What this block does
// - Search enabled receiver scans for codeword patterns
// - Search disabled receiver detects and reports nothing
// - Receive length selects 1, 10, 25 or change
// - Qualified message loads codeword and raises interrupt
// - Gaps allowed; different codeword restarts qualification
// - Change mode updates on each different pattern
// - Write sends 1, 10, 25 or endless patterns
// - Interrupt at message start; next write after it
// - Message done with nothing queued returns output
// - Changing transmit length ends continuous repetition
// - Mode field: disabled, codeword priority, link priority
// - Codeword priority preempts link output until done
// - Link buffer writes stay accepted during codeword output
// - Link priority waits for empty buffer and idle
// - Continuous message yields at the pattern boundary
// - Transmit codeword in bits five to zero
// - Pattern is eight ones, zero, codeword, zero
// - Uses the first data link's slot bits
// - Update sets fresh flag; read clears it
// - Update while fresh sets the overwrite flag
`timescale 1ns/1ns
module fct_transceiver
   import fct_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input wire logic fdl_rx_bit_en_i,
   input wire logic fdl_rx_bit_i,
   input wire logic fdl_tx_bit_en_i,
   input wire logic datalink_one_tx_bit_i,
   input wire logic datalink_one_buf_empty_i,
   input wire logic datalink_one_tx_idle_i,
   output logic fdl_tx_bit_o,
   output logic datalink_one_suspend_o,
   output logic rx_codeword_irq_o,
   output logic tx_codeword_irq_o,
   output logic tx_active_o,
   output logic rx_active_o
);
   import fct_pkg::*;

   // ------------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------------
   logic [7:0] ctrl_q;
   logic [5:0] tx_codeword_q;
   logic [5:0] rx_codeword_q;
   logic rx_codeword_fresh_q;
   logic rx_codeword_overwritten_q;
   logic tx_req_q;
   logic rx_search_enable;
   logic rx_pattern_integration;
   logic [1:0] rx_message_length_sel;
   logic [1:0] tx_message_length_sel;
   logic [1:0] tx_priority_mode;
   logic tx_enabled;
   logic dl_prio;
   logic wr_ctrl;
   logic wr_tx_cw;
   logic rd_rx_cw;

   assign rx_search_enable = ctrl_q[CTRL_RX_SEARCH_BIT];
   assign rx_pattern_integration = ctrl_q[CTRL_RX_INTEG_BIT];
   assign rx_message_length_sel = ctrl_q[CTRL_RX_LEN_LSB +: 2];
   assign tx_message_length_sel = ctrl_q[CTRL_TX_LEN_LSB +: 2];
   assign tx_priority_mode = ctrl_q[CTRL_TX_MODE_LSB +: 2];
   assign tx_enabled = tx_priority_mode[1];
   assign dl_prio = (tx_priority_mode == MODE_DL_PRIO);
   assign wr_ctrl = reg_wr_i && (reg_addr_i == CTRL_OFFSET);
   assign wr_tx_cw = reg_wr_i && (reg_addr_i == TX_CW_OFFSET);
   assign rd_rx_cw = reg_rd_i && (reg_addr_i == RX_CW_OFFSET);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= reg_wdata_i;
      end
   end

   // Unmapped offsets read as zero; reads take one cycle
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            CTRL_OFFSET: reg_rdata_o <= ctrl_q;
            TX_CW_OFFSET: reg_rdata_o <= {2'b00, tx_codeword_q};
            RX_CW_OFFSET: reg_rdata_o <= {rx_codeword_overwritten_q, rx_codeword_fresh_q,
                                          rx_codeword_q};
            STATUS_OFFSET: reg_rdata_o <= {tx_active_o, rx_active_o, 6'h00};
            default: reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Receive qualification
   // ------------------------------------------------------------------
   logic found;
   logic [5:0] found_cw;
   logic [5:0] cand_q;
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic done_q;
   logic new_cand;
   logic [4:0] need;
   logic change_mode;
   logic qualify;

   // Slot bit strobes are those of the first data-link controller
   fct_rx_pattern_finder u_finder (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .enable_i(rx_search_enable),
      .bit_en_i(fdl_rx_bit_en_i),
      .bit_i(fdl_rx_bit_i),
      .found_o(found),
      .codeword_o(found_cw)
   );

   assign change_mode = (rx_message_length_sel == LEN_CONT);
   // Integration asks for one more identical pattern; an errored one restarts
   assign need = fct_len_count(rx_message_length_sel) +
                 {4'h0, rx_pattern_integration};
   assign new_cand = (cnt_q == 5'h00) || (found_cw != cand_q);

   always_comb begin
      cnt_d = cnt_q;
      if (found) begin
         if (new_cand) begin
            cnt_d = COUNT_ONE;
         end else if (cnt_q != COUNT_MAX) begin
            cnt_d = cnt_q + 5'h01;
         end
      end
   end

   // Bits between patterns are ignored, so gaps never break a count
   assign qualify = rx_search_enable && found && (cnt_d == need) &&
                    (new_cand || !done_q) &&
                    (!change_mode || found_cw != rx_codeword_q);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cand_q <= CW_RESET;
         cnt_q <= 5'h00;
         done_q <= 1'b0;
      end else if (!rx_search_enable) begin
         cnt_q <= 5'h00;
         done_q <= 1'b0;
      end else if (found) begin
         cand_q <= found_cw;
         cnt_q <= cnt_d;
         done_q <= qualify || (done_q && !new_cand);
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rx_codeword_q <= CW_RESET;
         rx_codeword_fresh_q <= 1'b0;
         rx_codeword_overwritten_q <= 1'b0;
         rx_codeword_irq_o <= 1'b0;
      end else begin
         rx_codeword_irq_o <= qualify;
         if (qualify) begin
            rx_codeword_q <= found_cw;
            // Set wins over a read in the same cycle
            rx_codeword_fresh_q <= 1'b1;
            if (rx_codeword_fresh_q && !rd_rx_cw) begin
               rx_codeword_overwritten_q <= 1'b1;
            end
         end else if (rd_rx_cw) begin
            rx_codeword_fresh_q <= 1'b0;
            rx_codeword_overwritten_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rx_active_o <= 1'b0;
      end else begin
         rx_active_o <= rx_search_enable && (cnt_d != 5'h00) && !(done_q && !new_cand);
      end
   end

   // ------------------------------------------------------------------
   // Transmit sequencing
   // ------------------------------------------------------------------
   fct_tx_state_t state_q;
   logic msg_open_q;
   logic [5:0] cur_cw_q;
   logic [4:0] remain_q;
   logic grant;
   logic start_msg;
   logic load;
   logic shift;
   logic shift_bit;
   logic last;
   logic msg_end;
   logic yield;

   // Writes while disabled are dropped; set wins over the start clear
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         tx_codeword_q <= CW_RESET;
         tx_req_q <= 1'b0;
      end else if (wr_tx_cw && tx_enabled) begin
         tx_codeword_q <= reg_wdata_i[5:0];
         tx_req_q <= 1'b1;
      end else if (start_msg || !tx_enabled) begin
         tx_req_q <= 1'b0;
      end
   end

   // Codeword priority takes the slot at once, well inside eight bits
   assign grant = !dl_prio ||
                  (datalink_one_buf_empty_i && datalink_one_tx_idle_i);
   assign start_msg = (state_q == TX_WAIT) && tx_enabled && grant && !msg_open_q;
   assign load = (state_q == TX_WAIT) && tx_enabled && grant;
   assign shift = (state_q == TX_SEND) && fdl_tx_bit_en_i;
   // Continuous messages end only when the length field leaves that code or the mode field disables transmit
   function automatic logic [4:0] tx_end_count(input logic [1:0] sel,
                                               input logic [4:0] rem);
      if (sel == LEN_CONT) begin
         tx_end_count = rem + 5'h01;
      end else begin
         tx_end_count = COUNT_ONE;
      end
   endfunction

   assign msg_end = (remain_q == tx_end_count(tx_message_length_sel, remain_q));
   assign yield = dl_prio && !datalink_one_buf_empty_i;

   fct_tx_pattern_shifter u_shifter (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .load_i(load || (last && !msg_end && !yield)),
      .codeword_i(start_msg ? tx_codeword_q : cur_cw_q),
      .shift_i(shift),
      .bit_o(shift_bit),
      .last_o(last)
   );

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= TX_IDLE;
         msg_open_q <= 1'b0;
         cur_cw_q <= CW_RESET;
         remain_q <= 5'h00;
      end else if (!tx_enabled) begin
         state_q <= TX_IDLE;
         msg_open_q <= 1'b0;
      end else begin
         case (state_q)
            TX_IDLE: begin
               if (tx_req_q) begin
                  state_q <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               if (grant) begin
                  state_q <= TX_SEND;
                  if (start_msg) begin
                     msg_open_q <= 1'b1;
                     cur_cw_q <= tx_codeword_q;
                     remain_q <= fct_len_count(tx_message_length_sel);
                  end
               end
            end
            TX_SEND: begin
               if (last) begin
                  if (msg_end) begin
                     msg_open_q <= 1'b0;
                     // Nothing queued hands the slot back to the link
                     state_q <= tx_req_q ? TX_WAIT : TX_IDLE;
                  end else begin
                     if (tx_message_length_sel != LEN_CONT) begin
                        remain_q <= remain_q - 5'h01;
                     end
                     if (yield) begin
                        state_q <= TX_WAIT;
                     end
                  end
               end
            end
            default: begin
               state_q <= TX_IDLE;
               msg_open_q <= 1'b0;
            end
         endcase
      end
   end

   // The link buffer is never blocked here; only its output is held
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         fdl_tx_bit_o <= 1'b1;
         datalink_one_suspend_o <= 1'b0;
         tx_codeword_irq_o <= 1'b0;
         tx_active_o <= 1'b0;
      end else begin
         if (fdl_tx_bit_en_i) begin
            fdl_tx_bit_o <= (state_q == TX_SEND) ? shift_bit : datalink_one_tx_bit_i;
         end
         datalink_one_suspend_o <= (state_q == TX_SEND) || load;
         tx_codeword_irq_o <= start_msg;
         tx_active_o <= msg_open_q || start_msg;
      end
   end

endmodule

// *** tb/fct_transceiver_monitor.sv ***
// Port assertions for the FDL codeword transceiver.
// Assumes it is bound into fct_transceiver; one clock, async reset.
`timescale 1ns/1ns
module fct_transceiver_monitor
   import fct_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic fdl_rx_bit_en_i,
   input wire logic fdl_tx_bit_en_i,
   input wire logic datalink_one_tx_bit_i,
   input wire logic fdl_tx_bit_o,
   input wire logic datalink_one_suspend_o,
   input wire logic rx_codeword_irq_o,
   input wire logic tx_codeword_irq_o,
   input wire logic tx_active_o
);
   logic [7:0] ctrl_q;
   // ----
   // Control shadow, so mode-dependent checks know the mode
   // ----
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl_q <= CTRL_RESET;
      end else if (reg_wr_i && reg_addr_i == CTRL_OFFSET) begin
         ctrl_q <= reg_wdata_i;
      end
   end
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   a_rx_irq_pulse: assert property (rx_codeword_irq_o |=> !rx_codeword_irq_o)
      else $error("rx irq wider than one cycle");
   a_rx_irq_timing: assert property (rx_codeword_irq_o |-> $past(fdl_rx_bit_en_i, 2))
      else $error("rx irq not tied to a bit strobe");
   a_rx_off_quiet: assert property (!ctrl_q[CTRL_RX_SEARCH_BIT] [*4] |-> !rx_codeword_irq_o)
      else $error("rx irq while search off");
   a_tx_start_irq: assert property ($rose(tx_active_o) |-> tx_codeword_irq_o && datalink_one_suspend_o)
      else $error("message start without irq or slot");
   a_cw_prio_grab: assert property (reg_wr_i && reg_addr_i == TX_CW_OFFSET
      && ctrl_q[1:0] == MODE_CW_PRIO && !tx_active_o |-> ##[1:8] tx_codeword_irq_o)
      else $error("codeword priority start too late");
   a_tx_off_quiet: assert property (!ctrl_q[1] [*4] |-> !tx_active_o && !tx_codeword_irq_o)
      else $error("transmitter active while disabled");
   a_tx_bit_hold: assert property (!fdl_tx_bit_en_i |=> $stable(fdl_tx_bit_o))
      else $error("tx bit moved without strobe");
   a_link_pass_through: assert property (!$past(reset_i) && fdl_tx_bit_en_i
      && !datalink_one_suspend_o ##1 !datalink_one_suspend_o
      |-> fdl_tx_bit_o == $past(datalink_one_tx_bit_i))
      else $error("link bit not passed through");
   a_ctrl_readback: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == CTRL_OFFSET
      |=> reg_rdata_o == ctrl_q)
      else $error("control readback wrong");
endmodule
bind fct_transceiver fct_transceiver_monitor u_monitor (
   .clk_i(clk_i),
   .reset_i(reset_i),
   .reg_addr_i(reg_addr_i),
   .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i),
   .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o),
   .fdl_rx_bit_en_i(fdl_rx_bit_en_i),
   .fdl_tx_bit_en_i(fdl_tx_bit_en_i),
   .datalink_one_tx_bit_i(datalink_one_tx_bit_i),
   .fdl_tx_bit_o(fdl_tx_bit_o),
   .datalink_one_suspend_o(datalink_one_suspend_o),
   .rx_codeword_irq_o(rx_codeword_irq_o),
   .tx_codeword_irq_o(tx_codeword_irq_o),
   .tx_active_o(tx_active_o)
);

// *** tb/fct_far_end.sv ***
// Far-end line equipment: sends codeword patterns, counts those it hears carrying cw_i.
// Assumes one clock; drives its outputs on the falling edge.
`timescale 1ns/1ns
module fct_far_end
   import fct_pkg::*;
(
   input wire logic clk_i,
   input wire logic tx_bit_i,
   input wire logic [5:0] cw_i,
   output logic rx_bit_en_o,
   output logic rx_bit_o,
   output logic tx_bit_en_o,
   output int pat_cnt_o
);
   logic [1:0] div_q = 2'h0;
   logic [15:0] seen_q = 16'h0000;
   logic rx_en_q = 1'b0;
   logic rx_bit_q = 1'b0;
   logic tx_en_q = 1'b0;
   int cnt_q = 0;
   assign rx_bit_en_o = rx_en_q;
   assign rx_bit_o = rx_bit_q;
   assign tx_bit_en_o = tx_en_q;
   assign pat_cnt_o = cnt_q;
   // Slot bits every fourth line clock
   always @(negedge clk_i) begin
      div_q <= div_q + 2'h1;
      tx_en_q <= div_q == 2'h0;
   end
   // Looks half a cycle after the strobe edge, once the slot bit has settled
   always @(negedge clk_i) begin
      if (tx_en_q) begin
         seen_q = {tx_bit_i, seen_q[15:1]};
         if (seen_q == {1'b0, cw_i, 1'b0, FLAG_ONES}) begin
            cnt_q = cnt_q + 1;
         end
      end
   end
   task automatic send(input logic [5:0] cw, input int n);
      logic [15:0] p;
      p = {1'b0, cw, 1'b0, FLAG_ONES};
      repeat (n) begin
         // Three zero gap bits after each pattern
         for (int i = 0; i < 19; i++) begin
            repeat (3) @(negedge clk_i);
            rx_bit_q <= (i < 16) ? p[i] : 1'b0;
            rx_en_q <= 1'b1;
            @(negedge clk_i);
            rx_en_q <= 1'b0;
            rx_bit_q <= ~rx_bit_q;
         end
      end
   endtask
endmodule

// *** tb/fct_transceiver_tb.sv ***
// Self-checking bench for the FDL codeword transceiver.
// Assumes the far-end model and the port checker are compiled before it.
`timescale 1ns/1ns
module fct_transceiver_tb;
   import fct_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic dl_bit = 1'b0;
   logic buf_empty = 1'b1;
   logic dl_idle = 1'b1;
   logic [7:0] rdata;
   logic rx_en, rx_bit, tx_en, tx_bit, susp, rx_irq, tx_irq, tx_act;
   logic [7:0] rctl [3] = '{8'h90, 8'hD0, 8'hA0};
   logic [7:0] tctl [3] = '{8'h02, 8'h06, 8'h0A};
   int rn [3] = '{10, 11, 25};
   int tn [3] = '{1, 10, 25};
   int pats, p0;
   int rx_irqs = 0;
   int tx_irqs = 0;
   int fail_count = 0;
   int n_compared = 0;
   fct_transceiver DUT (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .reg_addr_i(addr),
      .reg_wr_i(wr),
      .reg_rd_i(rd),
      .reg_wdata_i(wdata),
      .reg_rdata_o(rdata),
      .fdl_rx_bit_en_i(rx_en),
      .fdl_rx_bit_i(rx_bit),
      .fdl_tx_bit_en_i(tx_en),
      .datalink_one_tx_bit_i(dl_bit),
      .datalink_one_buf_empty_i(buf_empty),
      .datalink_one_tx_idle_i(dl_idle),
      .fdl_tx_bit_o(tx_bit),
      .datalink_one_suspend_o(susp),
      .rx_codeword_irq_o(rx_irq),
      .tx_codeword_irq_o(tx_irq),
      .tx_active_o(tx_act),
      .rx_active_o()
   );
   fct_far_end far (
      .clk_i(clk_i),
      .tx_bit_i(tx_bit),
      .cw_i(6'h2D),
      .rx_bit_en_o(rx_en),
      .rx_bit_o(rx_bit),
      .tx_bit_en_o(tx_en),
      .pat_cnt_o(pats)
   );
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   // Alternating link bits can never look like a codeword pattern
   always @(negedge clk_i) begin
      if (tx_en === 1'b1) begin
         dl_bit <= ~dl_bit;
      end
   end
   // A pulse stands from one rising edge to the next, so one falling edge sees it
   always @(negedge clk_i) begin
      rx_irqs += (rx_irq === 1'b1);
      tx_irqs += (tx_irq === 1'b1);
   end
   // ----
   // Access and compare tasks
   // ----
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk_i);
      wr = 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_i);
      addr = a;
      rd = 1'b1;
      @(negedge clk_i);
      rd = 1'b0;
      n_compared++;
      if (rdata !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t reg %h got %h", $time, a, rdata);
      end
   endtask
   task automatic chkn(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t count %0d not %0d", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t flag %b", $time, got);
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wait_for(input int sel, input int lim);
      int k;
      for (k = 0; k < lim; k++) begin
         @(negedge clk_i);
         if ((sel == 0 && tx_act === 1'b0) || (sel == 1 && tx_irq === 1'b1)
            || (sel == 2 && susp === 1'b0)) break;
      end
      if (k == lim) begin
         fail_count++;
         $display("CHECK FAILED t=%0t wait %0d ran out", $time, sel);
         print_verdict;
      end
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      repeat (8) @(negedge clk_i);
      reset_i = 1'b0;
      rchk(CTRL_OFFSET, CTRL_RESET);
      rchk(RX_CW_OFFSET, 8'h00);
      rchk(8'h5C, 8'h00);
      wreg(TX_CW_OFFSET, 8'h2D);
      far.send(6'h15, 1);
      chkn(tx_irqs, 0);
      chkn(rx_irqs, 0);
      rchk(TX_CW_OFFSET, 8'h00);
      $display("disabled test done");
      wreg(CTRL_OFFSET, 8'h80);
      far.send(6'h15, 1);
      rchk(RX_CW_OFFSET, 8'h55);
      rchk(RX_CW_OFFSET, 8'h15);
      far.send(6'h2A, 1);
      far.send(6'h0B, 1);
      rchk(RX_CW_OFFSET, 8'hCB);
      chkn(rx_irqs, 3);
      for (int i = 0; i < 3; i++) begin
         wreg(CTRL_OFFSET, rctl[i]);
         far.send(6'(i + 7), rn[i] - 1);
         chkn(rx_irqs, 3 + i);
         rchk(STATUS_OFFSET, 8'h40);
         far.send(6'(i + 7), 1);
         chkn(rx_irqs, 4 + i);
      end
      wreg(CTRL_OFFSET, 8'h90);
      far.send(6'h0A, 5);
      far.send(6'h0B, 9);
      chkn(rx_irqs, 6);
      far.send(6'h0B, 1);
      chkn(rx_irqs, 7);
      wreg(CTRL_OFFSET, 8'hB0);
      far.send(6'h0B, 2);
      chkn(rx_irqs, 7);
      far.send(6'h33, 1);
      chkn(rx_irqs, 8);
      $display("receive test done");
      for (int i = 0; i < 3; i++) begin
         wreg(CTRL_OFFSET, tctl[i]);
         p0 = pats;
         rchk(STATUS_OFFSET, 8'h00);
         wreg(TX_CW_OFFSET, 8'hED);
         wait_for(1, 20);
         chkb(susp, 1'b1);
         wait_for(0, 3000);
         repeat (8) @(negedge clk_i);
         chkn(pats - p0, tn[i]);
         chkb(susp, 1'b0);
      end
      rchk(TX_CW_OFFSET, 8'h2D);
      wreg(CTRL_OFFSET, 8'h0E);
      wreg(TX_CW_OFFSET, 8'h2D);
      repeat (400) @(negedge clk_i);
      chkb(tx_act, 1'b1);
      wreg(CTRL_OFFSET, 8'h02);
      wait_for(0, 80);
      wreg(CTRL_OFFSET, 8'h03);
      buf_empty = 1'b0;
      dl_idle = 1'b0;
      wreg(TX_CW_OFFSET, 8'h2D);
      buf_empty = 1'b1;
      repeat (50) @(negedge clk_i);
      chkn(tx_irqs, 4);
      dl_idle = 1'b1;
      wait_for(1, 20);
      wait_for(0, 200);
      wreg(CTRL_OFFSET, 8'h0F);
      wreg(TX_CW_OFFSET, 8'h2D);
      wait_for(1, 20);
      buf_empty = 1'b0;
      wait_for(2, 80);
      chkb(tx_act, 1'b1);
      buf_empty = 1'b1;
      wreg(CTRL_OFFSET, 8'h00);
      wait_for(0, 20);
      $display("transmit test done");
      print_verdict;
   end
endmodule
